// ==== hw/mpsb_bank.sv ====
// per-axis motion parameter store with compare registers and read-back
`timescale 1ns/100ps
`default_nettype none
module mpsb_bank #(
    parameter int NUM_AXES = 2
) (
    // clock and reset
    input  wire logic                                 core_clk,
    input  wire logic                                 nrst,
    // host command port
    input  wire mpsb_pkg::mpsb_cmd_t                  cmd,
    input  wire logic [NUM_AXES-1:0]                  cmd_axis,
    // host read answer
    output logic [31:0]                               rd_data,
    output logic                                      rd_valid,
    output logic                                      cmd_err,
    // stored parameters
    output mpsb_pkg::mpsb_param_t [NUM_AXES-1:0]      axis_param,
    output logic [NUM_AXES-1:0][3:0][31:0]            compare_value,
    // comparators
    input  wire logic [NUM_AXES-1:0][3:0][31:0]       cmp_object,
    input  wire mpsb_pkg::mpsb_cond_t [NUM_AXES-1:0][3:0] cmp_cond,
    output logic [NUM_AXES-1:0][3:0]                  compare_hit,
    // synchronous action saving into a compare register
    input  wire logic [NUM_AXES-1:0][3:0]             sync_store,
    input  wire logic [NUM_AXES-1:0][31:0]            sync_store_value,
    // home search
    input  wire logic [NUM_AXES-1:0][2:0]             home_step,
    output logic [NUM_AXES-1:0][31:0]                 home_speed,
    output logic [NUM_AXES-1:0]                       home_slow_active,
    // speed stepping
    input  wire logic [NUM_AXES-1:0]                  driving,
    input  wire logic [NUM_AXES-1:0]                  accdec_mode,
    input  wire logic [NUM_AXES-1:0]                  const_phase,
    input  wire logic [NUM_AXES-1:0][31:0]            current_speed,
    output logic [NUM_AXES-1:0][31:0]                 speed_target,
    output logic [NUM_AXES-1:0]                       speed_target_load,
    output logic [NUM_AXES-1:0]                       speed_ramp_req,
    // timer and split
    input  wire logic [NUM_AXES-1:0][31:0]            timer_count,
    output logic [NUM_AXES-1:0]                       split_update,
    output logic [NUM_AXES-1:0]                       split_endless
);

    // range check used by the ring, home speed, speed step and timer parameters
    function automatic logic in_range(input logic [31:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // lowest selected axis answers a read
    function automatic int first_axis(input logic [NUM_AXES-1:0] sel);
        first_axis = 0;
        for (int i = NUM_AXES - 1; i >= 0; i--) begin
            if (sel[i]) begin
                first_axis = i;
            end
        end
    endfunction

    // command decode
    wire [31:0] data32   = {cmd.data_word_high, cmd.data_word_low};
    wire        is_off   = cmd.wr && (cmd.code == mpsb_pkg::CMD_ACCEL_OFFSET);
    wire        is_lring = cmd.wr && (cmd.code == mpsb_pkg::CMD_LOGIC_RING);
    wire        is_ering = cmd.wr && (cmd.code == mpsb_pkg::CMD_ENC_RING);
    wire        is_home  = cmd.wr && (cmd.code == mpsb_pkg::CMD_HOME_SLOW);
    wire        is_step  = cmd.wr && (cmd.code == mpsb_pkg::CMD_SPEED_STEP);
    wire        is_timer = cmd.wr && (cmd.code == mpsb_pkg::CMD_TIMER);
    wire        is_shape = cmd.wr && (cmd.code == mpsb_pkg::CMD_SPLIT_SHAPE);
    wire        is_count = cmd.wr && (cmd.code == mpsb_pkg::CMD_SPLIT_COUNT);
    wire        is_inc   = cmd.wr && (cmd.code == mpsb_pkg::CMD_SPEED_INC);
    wire        is_dec   = cmd.wr && (cmd.code == mpsb_pkg::CMD_SPEED_DEC);
    wire        is_cmpw  = cmd.wr && (cmd.code[7:2] == mpsb_pkg::CMD_COMPARE_0[7:2]);
    wire        is_cmpr  = cmd.wr && (cmd.code[7:2] == mpsb_pkg::CMD_RD_COMPARE_0[7:2]);
    wire        is_rtim  = cmd.wr && (cmd.code == mpsb_pkg::CMD_RD_TIMER);
    wire        is_rspl  = cmd.wr && (cmd.code == mpsb_pkg::CMD_RD_SPLIT);
    wire [1:0]  cmp_idx  = cmd.code[1:0];

    // legality of each data value
    wire ring_ok  = in_range(data32, 32'h0000_0001, mpsb_pkg::RING_MAX_HI)
                    || (data32 == mpsb_pkg::RING_DISABLE);
    wire home_ok  = in_range(data32, 32'h0000_0001, mpsb_pkg::HOME_SPEED_HI);
    wire step_ok  = in_range(data32, 32'h0000_0001, mpsb_pkg::STEP_HI);
    wire timer_ok = in_range(data32, 32'h0000_0001, mpsb_pkg::TIMER_HI);
    wire shape_ok = (cmd.data_word_low >= mpsb_pkg::SPLIT_LEN_LO)
                    && (cmd.data_word_high != 16'h0000)
                    && (cmd.data_word_high <= mpsb_pkg::SPLIT_WID_HI);
    wire bad_val  = (is_lring && !ring_ok) || (is_ering && !ring_ok)
                    || (is_home && !home_ok) || (is_step && !step_ok)
                    || (is_timer && !timer_ok) || (is_shape && !shape_ok);

    mpsb_pkg::mpsb_param_t [NUM_AXES-1:0]    param_reg;
    logic [NUM_AXES-1:0][3:0][31:0]           cmp_reg;
    logic [NUM_AXES-1:0][31:0]                target_reg;
    logic [NUM_AXES-1:0]                      target_load_reg;
    logic [NUM_AXES-1:0]                      ramp_reg;
    logic [NUM_AXES-1:0]                      split_upd_reg;

    genvar a;
    genvar k;
    generate
        for (a = 0; a < NUM_AXES; a++) begin : g_axis
            mpsb_pkg::mpsb_param_t p_next;
            logic [31:0]           target_next;
            wire                   sel     = cmd_axis[a];
            wire                   step_go = sel && (is_inc || is_dec) && driving[a];

            // parameter update for this axis only; illegal values leave it unchanged
            always_comb begin
                p_next = param_reg[a];
                if (sel) begin
                    if (is_off) begin
                        p_next.accel_count_offset = cmd.data_word_low;
                    end
                    if (is_lring && ring_ok) begin
                        p_next.logical_ring_max = data32;
                    end
                    if (is_ering && ring_ok) begin
                        p_next.encoder_ring_max = data32;
                    end
                    if (is_home && home_ok) begin
                        p_next.home_slow_speed = data32;
                    end
                    if (is_step && step_ok) begin
                        p_next.speed_step_value = data32;
                    end
                    if (is_timer && timer_ok) begin
                        p_next.timer_period = data32;
                    end
                    if (is_shape && shape_ok) begin
                        p_next.split_length = cmd.data_word_low;
                        p_next.split_width  = cmd.data_word_high;
                    end
                    if (is_count) begin
                        p_next.split_count = cmd.data_word_low;
                    end
                end
            end

            // new speed target; decrease floors at one so the axis never reverses
            always_comb begin
                target_next = 32'(current_speed[a] + param_reg[a].speed_step_value);
                if (is_dec) begin
                    if (current_speed[a] > param_reg[a].speed_step_value) begin
                        target_next = 32'(current_speed[a] - param_reg[a].speed_step_value);
                    end else begin
                        target_next = 32'h0000_0001;
                    end
                end
            end

            // parameter and speed target state
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    param_reg[a]       <= mpsb_pkg::RST_PARAM;
                    target_reg[a]      <= mpsb_pkg::RST_PARAM32;
                    target_load_reg[a] <= 1'b0;
                    ramp_reg[a]        <= 1'b0;
                    split_upd_reg[a]   <= 1'b0;
                end else begin
                    param_reg[a]       <= p_next;
                    target_load_reg[a] <= step_go;
                    ramp_reg[a]        <= step_go && accdec_mode[a] && const_phase[a];
                    split_upd_reg[a]   <= sel && ((is_shape && shape_ok) || is_count);
                    if (step_go) begin
                        target_reg[a] <= target_next;
                    end
                end
            end

            for (k = 0; k < 4; k++) begin : g_cmp
                // host write wins over a sync save landing in the same cycle
                always_ff @(posedge core_clk) begin
                    if (!nrst) begin
                        cmp_reg[a][k] <= mpsb_pkg::RST_PARAM32;
                    end else if (sel && is_cmpw && (cmp_idx == k)) begin
                        cmp_reg[a][k] <= data32;
                    end else if (sync_store[a][k]) begin
                        cmp_reg[a][k] <= sync_store_value[a];
                    end
                end

                mpsb_cmp u_cmp (
                    .core_clk     (core_clk),
                    .nrst         (nrst),
                    .object_value (cmp_object[a][k]),
                    .ref_value    (cmp_reg[a][k]),
                    .cond         (cmp_cond[a][k]),
                    .hit          (compare_hit[a][k])
                );
            end

            // slow speed only in the two slow search steps
            assign home_slow_active[a] = (home_step[a] == mpsb_pkg::HOME_STEP_2)
                                         || (home_step[a] == mpsb_pkg::HOME_STEP_3);
            assign home_speed[a]       = home_slow_active[a] ? param_reg[a].home_slow_speed
                                                             : 32'h0000_0000;
            assign split_endless[a]    = (param_reg[a].split_count == 16'h0000);
        end
    endgenerate

    // read answer from the lowest selected axis
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    logic        rd_valid_reg;
    logic        err_reg;
    int          rd_ax;
    wire         rd_hit = (is_cmpr || is_rtim || is_rspl) && (cmd_axis != '0);

    assign rd_ax = first_axis(cmd_axis);

    // read mux
    always_comb begin
        rd_data_next = rd_data_reg;
        if (is_cmpr) begin
            rd_data_next = cmp_reg[rd_ax][cmp_idx];
        end else if (is_rtim) begin
            rd_data_next = timer_count[rd_ax];
        end else if (is_rspl) begin
            rd_data_next = {param_reg[rd_ax].split_width,
                            param_reg[rd_ax].split_length};
        end
    end

    // read data holds until the next read; valid is a one-cycle pulse
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_data_reg  <= mpsb_pkg::RST_PARAM32;
            rd_valid_reg <= 1'b0;
            err_reg      <= 1'b0;
        end else begin
            rd_valid_reg <= rd_hit;
            err_reg      <= bad_val;
            if (rd_hit) begin
                rd_data_reg <= rd_data_next;
            end
        end
    end

    // outputs
    assign rd_data           = rd_data_reg;
    assign rd_valid          = rd_valid_reg;
    assign cmd_err           = err_reg;
    assign axis_param        = param_reg;
    assign compare_value     = cmp_reg;
    assign speed_target      = target_reg;
    assign speed_target_load = target_load_reg;
    assign speed_ramp_req    = ramp_reg;
    assign split_update      = split_upd_reg;

endmodule // mpsb_bank
`default_nettype wire

// ==== hw/mpsb_cmp.sv ====
// one signed compare register against its comparative object
`timescale 1ns/100ps
`default_nettype none
module mpsb_cmp (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               nrst,
    // operands
    input  wire logic signed [31:0] object_value,
    input  wire logic signed [31:0] ref_value,
    input  wire mpsb_pkg::mpsb_cond_t cond,
    // result
    output logic                    hit
);
    logic hit_reg;
    logic hit_next;
    wire  ge = (object_value >= ref_value);
    wire  eq = (object_value == ref_value);

    // condition select
    always_comb begin
        case (cond)
            mpsb_pkg::MPSB_GE: hit_next = ge;
            mpsb_pkg::MPSB_GT: hit_next = ge & ~eq;
            mpsb_pkg::MPSB_EQ: hit_next = eq;
            mpsb_pkg::MPSB_LT: hit_next = ~ge;
            default:           hit_next = 1'b0;
        endcase
    end

    // registered so the outcome is glitch free for the pin and the sync logic
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= hit_next;
        end
    end

    assign hit = hit_reg;
endmodule // mpsb_cmp
`default_nettype wire

// ==== hw/mpsb_pkg.sv ====
// package: command codes, reset values and carriers of the motion parameter bank
// Notes on behaviour
// - offset: signed 16 bits, low data word only
// - reset clears the offset
// - logical ring max: 1..7FFF_FFFF or all ones
// - encoder ring max: 1..7FFF_FFFF or all ones
// - reset sets both ring maxima to all ones
// - four signed 32-bit compare registers, own read code each
// - compare outcome feeds pin, sync trigger and interrupt
// - compare registers are sync load/save source or target
// - slow home speed 1..8,000,000 pps, home steps two and three
// - speed step 1..1,000,000 pps, added or subtracted while driving
// - step at constant speed ramps to new target, then constant
// - timer period 1..7FFF_FFFF us; running count readable
// - split length 2..65535 low word, width 1..65534 high word
// - new split values taken during split output
// - split length and width read back by own code
// - split count 0..65535; zero runs until stopped
// - split count taken anytime, low word only
package mpsb_pkg;

    // command codes
    localparam logic [7:0] CMD_ACCEL_OFFSET = 8'h0D;
    localparam logic [7:0] CMD_LOGIC_RING   = 8'h0E;
    localparam logic [7:0] CMD_ENC_RING     = 8'h0F;
    localparam logic [7:0] CMD_COMPARE_0    = 8'h10; // 10h..13h, one per compare register
    localparam logic [7:0] CMD_HOME_SLOW    = 8'h14;
    localparam logic [7:0] CMD_SPEED_STEP   = 8'h15;
    localparam logic [7:0] CMD_TIMER        = 8'h16;
    localparam logic [7:0] CMD_SPLIT_SHAPE  = 8'h17;
    localparam logic [7:0] CMD_SPLIT_COUNT  = 8'h18;
    localparam logic [7:0] CMD_RD_COMPARE_0 = 8'h34; // 34h..37h
    localparam logic [7:0] CMD_RD_TIMER     = 8'h38;
    localparam logic [7:0] CMD_RD_SPLIT     = 8'h47;
    localparam logic [7:0] CMD_SPEED_INC    = 8'h70;
    localparam logic [7:0] CMD_SPEED_DEC    = 8'h71;

    // legal ranges
    localparam logic [31:0] RING_MAX_HI   = 32'h7FFF_FFFF;
    localparam logic [31:0] RING_DISABLE  = 32'hFFFF_FFFF;
    localparam logic [31:0] HOME_SPEED_HI = 32'h007A_1200; // 8,000,000
    localparam logic [31:0] STEP_HI       = 32'h000F_4240; // 1,000,000
    localparam logic [31:0] TIMER_HI      = 32'h7FFF_FFFF;
    localparam logic [15:0] SPLIT_LEN_LO  = 16'h0002;
    localparam logic [15:0] SPLIT_WID_HI  = 16'hFFFE;

    // reset values
    localparam logic [15:0] RST_ACCEL_OFFSET = 16'h0000;
    localparam logic [31:0] RST_RING_MAX     = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_PARAM32      = 32'h0000_0000;
    localparam logic [15:0] RST_PARAM16      = 16'h0000;

    // home search steps that use the slow speed
    localparam logic [2:0] HOME_STEP_2 = 3'h2;
    localparam logic [2:0] HOME_STEP_3 = 3'h3;

    // compare conditions
    typedef enum logic [1:0] {
        MPSB_GE = 2'h0,
        MPSB_GT = 2'h1,
        MPSB_EQ = 2'h2,
        MPSB_LT = 2'h3
    } mpsb_cond_t;

    // one axis worth of stored parameters
    typedef struct packed {
        logic [15:0] accel_count_offset;
        logic [31:0] logical_ring_max;
        logic [31:0] encoder_ring_max;
        logic [31:0] home_slow_speed;
        logic [31:0] speed_step_value;
        logic [31:0] timer_period;
        logic [15:0] split_length;
        logic [15:0] split_width;
        logic [15:0] split_count;
    } mpsb_param_t;

    localparam mpsb_param_t RST_PARAM = '{
        accel_count_offset: RST_ACCEL_OFFSET,
        logical_ring_max:   RST_RING_MAX,
        encoder_ring_max:   RST_RING_MAX,
        home_slow_speed:    RST_PARAM32,
        speed_step_value:   RST_PARAM32,
        timer_period:       RST_PARAM32,
        split_length:       RST_PARAM16,
        split_width:        RST_PARAM16,
        split_count:        RST_PARAM16
    };

    // host command carrier
    typedef struct packed {
        logic        wr;
        logic [7:0]  code;
        logic [15:0] data_word_low;
        logic [15:0] data_word_high;
    } mpsb_cmd_t;

endpackage

// ==== tb/mpsb_host.sv ====
// host model: issues one parameter command at a time
`timescale 1ns/100ps
`default_nettype none
module mpsb_host #(
    parameter int NUM_AXES = 2
) (
    // clock
    input  wire logic               core_clk,
    // command port toward the bank
    output var mpsb_pkg::mpsb_cmd_t cmd,
    output var logic [NUM_AXES-1:0] cmd_axis
);
    initial begin
        cmd = '0;
        cmd_axis = '0;
    end
    // data words ride with the code
    task automatic send(input logic [7:0] code, input logic [31:0] data,
                        input logic [NUM_AXES-1:0] axes);
        @(negedge core_clk);
        cmd <= '{1'b1, code, data[15:0], data[31:16]};
        cmd_axis <= axes;
        @(negedge core_clk);
        cmd.wr <= 1'b0;
        // released data lines show the inverse
        cmd.data_word_low <= ~data[15:0];
        cmd.data_word_high <= ~data[31:16];
    endtask
endmodule // mpsb_host
`default_nettype wire

// ==== tb/mpsb_properties.sv ====
// checker: port timing relations of the motion parameter bank
`timescale 1ns/100ps
`default_nettype none
module mpsb_properties #(
    parameter int NUM_AXES = 2
) (
    // clock and reset
    input wire logic                                 core_clk,
    input wire logic                                 nrst,
    // command and answer
    input wire mpsb_pkg::mpsb_cmd_t                  cmd,
    input wire logic [NUM_AXES-1:0]                  cmd_axis,
    input wire logic [31:0]                          rd_data,
    input wire logic                                 rd_valid,
    input wire logic                                 cmd_err,
    // stored values
    input wire mpsb_pkg::mpsb_param_t [NUM_AXES-1:0] axis_param,
    input wire logic [NUM_AXES-1:0][3:0][31:0]       compare_value,
    input wire logic [NUM_AXES-1:0][3:0]             sync_store,
    input wire logic [NUM_AXES-1:0][31:0]            sync_store_value,
    // motion side
    input wire logic [NUM_AXES-1:0][2:0]             home_step,
    input wire logic [NUM_AXES-1:0][31:0]            home_speed,
    input wire logic [NUM_AXES-1:0]                  driving,
    input wire logic [NUM_AXES-1:0]                  accdec_mode,
    input wire logic [NUM_AXES-1:0]                  const_phase,
    input wire logic [NUM_AXES-1:0][31:0]            current_speed,
    input wire logic [NUM_AXES-1:0][31:0]            speed_target,
    input wire logic [NUM_AXES-1:0]                  speed_target_load,
    input wire logic [NUM_AXES-1:0]                  speed_ramp_req,
    input wire logic [NUM_AXES-1:0]                  split_update
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // a command taken for axis zero; the offset, ring, step and split shape relations start from one
    sequence s_wr0(logic [7:0] c);
        cmd.wr && cmd.code == c && cmd_axis[0];
    endsequence
    a_offset_low_word: assert property (s_wr0(mpsb_pkg::CMD_ACCEL_OFFSET) |=> axis_param[0].accel_count_offset == $past(cmd.data_word_low)) else $error("offset not from low word");
    a_ring_zero_refused: assert property (s_wr0(mpsb_pkg::CMD_LOGIC_RING) ##0 cmd.data_word_low == 16'h0000 && cmd.data_word_high == 16'h0000 |=> cmd_err && $stable(axis_param[0].logical_ring_max)) else $error("zero ring taken");
    a_enc_ring_take: assert property (s_wr0(mpsb_pkg::CMD_ENC_RING) ##0 ({cmd.data_word_high, cmd.data_word_low} - 32'h0000_0001 < mpsb_pkg::RING_MAX_HI) |=> axis_param[0].encoder_ring_max == $past({cmd.data_word_high, cmd.data_word_low})) else $error("encoder ring lost");
    a_cmp_read_back: assert property (cmd.wr && cmd_axis[0] && cmd.code[7:2] == mpsb_pkg::CMD_RD_COMPARE_0[7:2] |=> rd_valid && rd_data == $past(compare_value[0][cmd.code[1:0]])) else $error("compare read wrong");
    a_sync_save_cmp: assert property (sync_store[0][3] && !cmd.wr |=> compare_value[0][3] == $past(sync_store_value[0])) else $error("sync save lost");
    a_home_slow_speed: assert property (home_speed[0] == ((home_step[0] == mpsb_pkg::HOME_STEP_2 || home_step[0] == mpsb_pkg::HOME_STEP_3) ? axis_param[0].home_slow_speed : 32'h0000_0000)) else $error("home speed wrong");
    a_step_increase: assert property (s_wr0(mpsb_pkg::CMD_SPEED_INC) ##0 driving[0] |=> speed_target_load[0] && speed_target[0] == $past(32'(current_speed[0] + axis_param[0].speed_step_value)) && speed_ramp_req[0] == $past(accdec_mode[0] && const_phase[0])) else $error("speed step wrong");
    a_split_shape_take: assert property (s_wr0(mpsb_pkg::CMD_SPLIT_SHAPE) ##0 cmd.data_word_low >= mpsb_pkg::SPLIT_LEN_LO && cmd.data_word_high != 16'h0000 && cmd.data_word_high <= mpsb_pkg::SPLIT_WID_HI |=> split_update[0] && axis_param[0].split_length == $past(cmd.data_word_low) && axis_param[0].split_width == $past(cmd.data_word_high)) else $error("split shape lost");
    a_axis_untouched: assert property (!(cmd.wr && cmd_axis[1]) |=> $stable(axis_param[1])) else $error("unselected axis moved");
endmodule // mpsb_properties
bind mpsb_bank mpsb_properties #(.NUM_AXES(NUM_AXES)) i_props (.*);
`default_nettype wire

// ==== tb/test_motion_param_setting_bank.sv ====
// testbench: random and corner commands against the motion parameter bank
`timescale 1ns/100ps
`default_nettype none
module test_motion_param_setting_bank;
    localparam int NA = 2;
    // clock, reset, counters
    logic core_clk;
    logic nrst;
    int   mismatches = 0;
    int   check_count = 0;
    int   seed;
    // bench driven inputs
    mpsb_pkg::mpsb_cmd_t cmd;
    logic [NA-1:0] cmd_axis, driving, accdec_mode, const_phase;
    logic [NA-1:0][3:0][31:0] cmp_object, compare_value;
    mpsb_pkg::mpsb_cond_t [NA-1:0][3:0] cmp_cond;
    logic [NA-1:0][3:0] sync_store, compare_hit;
    logic [NA-1:0][31:0] sync_store_value, current_speed, timer_count, home_speed, speed_target;
    logic [NA-1:0][2:0] home_step;
    // observed outputs
    logic [31:0] rd_data;
    logic rd_valid, cmd_err;
    mpsb_pkg::mpsb_param_t [NA-1:0] axis_param;
    logic [NA-1:0] home_slow_active, speed_target_load, speed_ramp_req, split_update, split_endless;

    mpsb_host #(.NUM_AXES(NA)) i_host (.core_clk, .cmd, .cmd_axis);
    mpsb_bank #(.NUM_AXES(NA)) i_dut (.*);

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: flag got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // legal ring maximum: 1..7FFF_FFFF or all ones
    function automatic logic ring_ok(input logic [31:0] v);
        return (v != 32'h0 && v <= mpsb_pkg::RING_MAX_HI) || v == mpsb_pkg::RING_DISABLE;
    endfunction
    function automatic logic shape_ok(input logic [31:0] v);
        return v[15:0] >= mpsb_pkg::SPLIT_LEN_LO && v[31:16] != 16'h0 &&
               v[31:16] <= mpsb_pkg::SPLIT_WID_HI;
    endfunction

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // some 70 cycles are needed; cut a hang long after that
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        logic [31:0] v;
        logic [31:0] cur;
        logic [31:0] exp_s;
        logic [31:0] exp_r [2];
        logic [31:0] rings [5];
        logic [31:0] shapes [4];
        seed = 40;
        rings = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF};
        shapes = '{32'h0001_0002, 32'hFFFE_FFFF, 32'hFFFF_0010, 32'h0005_0001};
        nrst = 1'b0;
        cmp_object = '0;
        cmp_cond = '{default: mpsb_pkg::MPSB_GE};
        {sync_store, sync_store_value, home_step, current_speed, timer_count} = '0;
        {driving, accdec_mode, const_phase} = '0;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        for (int a = 0; a < NA; a++) begin
            chk32({16'h0, axis_param[a].accel_count_offset}, 32'h0000_0000);
            chk32(axis_param[a].logical_ring_max, 32'hFFFF_FFFF);
            chk32(axis_param[a].encoder_ring_max, 32'hFFFF_FFFF);
        end
        v = $random(seed);
        i_host.send(mpsb_pkg::CMD_ACCEL_OFFSET, v, 2'b01);
        chk32({16'h0, axis_param[0].accel_count_offset}, {16'h0, v[15:0]});
        chk32({16'h0, axis_param[1].accel_count_offset}, 32'h0000_0000);
        exp_r = '{32'hFFFF_FFFF, 32'hFFFF_FFFF};
        // rings alternate logical and encoder, legal and refused values
        for (int i = 0; i < 5; i++) begin
            i_host.send(i[0] ? mpsb_pkg::CMD_ENC_RING : mpsb_pkg::CMD_LOGIC_RING, rings[i], 2'b01);
            chk1(cmd_err, !ring_ok(rings[i]));
            if (ring_ok(rings[i])) exp_r[i[0]] = rings[i];
            chk32(axis_param[0].logical_ring_max, exp_r[0]);
            chk32(axis_param[0].encoder_ring_max, exp_r[1]);
        end
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            cmp_object[0][k] = (k == 0) ? v : $random(seed);
            i_host.send(mpsb_pkg::CMD_COMPARE_0 + 8'(k), v, 2'b11);
            i_host.send(mpsb_pkg::CMD_RD_COMPARE_0 + 8'(k), 32'h0, 2'b01);
            chk1(rd_valid, 1'b1);
            chk32(rd_data, v);
            chk1(compare_hit[0][k], $signed(cmp_object[0][k]) >= $signed(v));
        end
        v = $random(seed);
        sync_store_value[0] = v;
        sync_store[0][3] = 1'b1;
        @(negedge core_clk);
        sync_store = '0;
        chk32(compare_value[0][3], v);
        i_host.send(mpsb_pkg::CMD_HOME_SLOW, mpsb_pkg::HOME_SPEED_HI, 2'b01);
        i_host.send(mpsb_pkg::CMD_HOME_SLOW, mpsb_pkg::HOME_SPEED_HI + 32'h1, 2'b01);
        chk1(cmd_err, 1'b1);
        for (int s = 0; s < 5; s++) begin
            home_step[0] = 3'(s);
            #1;
            chk32(home_speed[0], (s == 2 || s == 3) ? mpsb_pkg::HOME_SPEED_HI : 32'h0);
            chk1(home_slow_active[0], s == 2 || s == 3);
        end
        i_host.send(mpsb_pkg::CMD_SPEED_STEP, mpsb_pkg::STEP_HI, 2'b01);
        v = $random(seed);
        cur = {8'h01, v[23:0]};
        current_speed[0] = cur;
        {driving, accdec_mode, const_phase} = {2'b01, 2'b01, 2'b01};
        i_host.send(mpsb_pkg::CMD_SPEED_INC, 32'h0, 2'b01);
        chk32(speed_target[0], cur + mpsb_pkg::STEP_HI);
        chk1(speed_target_load[0], 1'b1);
        chk1(speed_ramp_req[0], 1'b1);
        const_phase = '0;
        i_host.send(mpsb_pkg::CMD_SPEED_DEC, 32'h0, 2'b01);
        chk32(speed_target[0], cur - mpsb_pkg::STEP_HI);
        chk1(speed_ramp_req[0], 1'b0);
        driving = '0;
        i_host.send(mpsb_pkg::CMD_SPEED_INC, 32'h0, 2'b01);
        chk1(speed_target_load[0], 1'b0);
        timer_count[0] = $random(seed);
        i_host.send(mpsb_pkg::CMD_TIMER, mpsb_pkg::TIMER_HI, 2'b01);
        chk32(axis_param[0].timer_period, mpsb_pkg::TIMER_HI);
        i_host.send(mpsb_pkg::CMD_RD_TIMER, 32'h0, 2'b01);
        chk32(rd_data, timer_count[0]);
        exp_s = 32'h0;
        for (int i = 0; i < 4; i++) begin
            i_host.send(mpsb_pkg::CMD_SPLIT_SHAPE, shapes[i], 2'b01);
            chk1(split_update[0], shape_ok(shapes[i]));
            chk1(cmd_err, !shape_ok(shapes[i]));
            if (shape_ok(shapes[i])) exp_s = shapes[i];
            i_host.send(mpsb_pkg::CMD_RD_SPLIT, 32'h0, 2'b01);
            chk32(rd_data, exp_s);
        end
        v = $random(seed);
        i_host.send(mpsb_pkg::CMD_SPLIT_COUNT, {v[31:16], 16'h0000}, 2'b01);
        chk1(split_endless[0], 1'b1);
        i_host.send(mpsb_pkg::CMD_SPLIT_COUNT, 32'hFFFF_FFFF, 2'b01);
        chk32({16'h0, axis_param[0].split_count}, 32'h0000_FFFF);
        chk1(split_endless[0], 1'b0);
        results();
    end
endmodule // test_motion_param_setting_bank
`default_nettype wire
